// *** hdl/mrs_decoder.sv ***
`timescale 1ns/100ps
`include "mrs_defs.svh"

// Notes on behaviour
// - Low 64 kB window shows flash or SRAM
// - 4 kB at 0xFFFF0000 holds the register area
// - SRAM 1024 words at 0x40000, full speed
// - Undefined address access raises data abort
// - Words stored little-endian
// - SRAM takes byte, half and word accesses
// - Remap bit 0 selects SRAM at zero
// - Every reset clears the remap selection
// - After reset kernel runs, then vector zero
// - Status records each of four reset sources since power-on
// - Writing status requests a software reset
// - Clear register ones clear matching status bits
// - Interrupt requests pass a synchroniser
// - Fast interrupt worst latency 50 cycles
// - Exception entry runs 32-bit instruction set
// - Flash top 2 kB kernel, hidden from user
// - Clear write keeping software bit resets again
module mrs_decoder
    import mrs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Reset causes from the reset generator
    input wire logic rst_cause_por,
    input wire logic rst_cause_wdog,
    input wire logic rst_cause_ext,
    output logic sw_reset_req,
    // Kernel boot handshake
    input wire logic kernel_done,
    output logic kernel_active,
    // Core bus
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic bus_ack,
    output logic bus_abort,
    output logic [31:0] bus_rdata,
    // Flash controller port
    output logic flash_req,
    output logic flash_write,
    output logic [1:0] flash_size,
    output logic [15:0] flash_addr,
    output logic [31:0] flash_wdata,
    input wire logic [31:0] flash_rdata,
    // Other register blocks
    output logic mmr_req,
    output logic mmr_write,
    output logic [11:0] mmr_addr,
    output logic [31:0] mmr_wdata,
    input wire logic [31:0] mmr_rdata,
    // Interrupt requests
    input wire logic fast_interrupt_request_pin,
    input wire logic irq_pin,
    output logic fast_interrupt_request_sync,
    output logic irq_sync,
    output logic exc_wide_isa
);

    mrs_state_t st_q;
    mrs_state_t st_d;
    logic [31:0] sram_mem [0:`MRS_SRAM_WORDS-1];
    logic [31:0] sram_word;
    mrs_target_t tgt;
    logic [15:0] flash_off;
    logic [11:0] sram_off;
    logic aligned;
    logic [3:0] lane_en;
    logic [31:0] lane_data;
    logic [31:0] raw_word;
    logic [31:0] shifted;
    logic sram_we;

    ////////////////////////////////////////////////////////////////////
    // Interrupt synchronisers
    // synchronise interrupt requests
    mrs_sync3 u_sync_fiq (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(fast_interrupt_request_pin),
        .level(fast_interrupt_request_sync)
    );

    mrs_sync3 u_sync_irq (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(irq_pin),
        .level(irq_sync)
    );

    // three stages leave the core ample latency budget
    // core enters every exception in the wide set
    assign exc_wide_isa = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb
    begin
        tgt = MRS_TGT_NONE;
        flash_off = bus_addr[15:0];
        sram_off = bus_addr[11:0];
        // low window follows the remap bit
        if ((bus_addr >> `MRS_WIN_BITS) == (`MRS_WIN_BASE >> `MRS_WIN_BITS))
        begin
            // remap set shows SRAM at zero
            if (st_q.remap)
            begin
                if (bus_addr[15:`MRS_SRAM_BITS] == 4'h0)
                begin
                    tgt = MRS_TGT_SRAM;
                end
            end
            else
            begin
                tgt = MRS_TGT_FLASH;
            end
        end
        else if ((bus_addr >> `MRS_SRAM_BITS) ==
                 (`MRS_SRAM_BASE >> `MRS_SRAM_BITS))
        begin
            tgt = MRS_TGT_SRAM;
        end
        else if ((bus_addr >> `MRS_FLASH_BITS) ==
                 (`MRS_FLASH_BASE >> `MRS_FLASH_BITS))
        begin
            tgt = MRS_TGT_FLASH;
        end
        else if ((bus_addr >> `MRS_MMR_BITS) ==
                 (`MRS_MMR_BASE >> `MRS_MMR_BITS))
        begin
            if (bus_addr == `MRS_REMAP_ADDR ||
                bus_addr == `MRS_STATUS_ADDR ||
                bus_addr == `MRS_CLEAR_ADDR)
            begin
                tgt = MRS_TGT_REG;
            end
            else
            begin
                tgt = MRS_TGT_MMR;
            end
        end
        // kernel area hidden once user code runs
        if (tgt == MRS_TGT_FLASH && !st_q.kernel &&
            flash_off >= `MRS_KERNEL_BASE)
        begin
            tgt = MRS_TGT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Byte lanes; misaligned halves and words are refused
    always_comb
    begin
        aligned = 1'b1;
        lane_en = 4'b0000;
        lane_data = bus_wdata;
        case (bus_size)
            `MRS_SIZE_BYTE:
            begin
                // lowest address is the low byte lane
                lane_en = 4'b0001 << bus_addr[1:0];
                lane_data = {4{bus_wdata[7:0]}};
            end
            `MRS_SIZE_HALF:
            begin
                aligned = ~bus_addr[0];
                lane_en = 4'b0011 << bus_addr[1:0];
                lane_data = {2{bus_wdata[15:0]}};
            end
            `MRS_SIZE_WORD:
            begin
                aligned = (bus_addr[1:0] == 2'h0);
                lane_en = 4'b1111;
            end
            default:
            begin
                aligned = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Forwarding to flash and other register blocks
    always_comb
    begin
        flash_req = bus_valid && aligned && (tgt == MRS_TGT_FLASH);
        mmr_req = bus_valid && aligned && (tgt == MRS_TGT_MMR);
    end

    assign flash_write = bus_write;
    assign flash_size = bus_size;
    assign flash_addr = flash_off;
    assign flash_wdata = lane_data;
    assign mmr_write = bus_write;
    assign mmr_addr = bus_addr[11:0];
    assign mmr_wdata = lane_data;

    ////////////////////////////////////////////////////////////////////
    // SRAM array, one word per cycle with byte enables
    assign sram_we = bus_valid && bus_write && aligned &&
                     (tgt == MRS_TGT_SRAM);
    assign sram_word = sram_mem[sram_off[11:2]];

    // byte, half and word writes by lane
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (sram_we && lane_en[i])
            begin
                sram_mem[sram_off[11:2]][i*8 +: 8] <= lane_data[i*8 +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read word selection and lane extraction
    always_comb
    begin
        raw_word = 32'h0000_0000;
        case (tgt)
            MRS_TGT_SRAM:
            begin
                raw_word = sram_word;
            end
            MRS_TGT_FLASH:
            begin
                raw_word = flash_rdata;
            end
            MRS_TGT_MMR:
            begin
                raw_word = mmr_rdata;
            end
            MRS_TGT_REG:
            begin
                // Reserved bits and the clear register read as zero
                if (bus_addr == `MRS_REMAP_ADDR)
                begin
                    raw_word = {31'h0000_0000, st_q.remap};
                end
                else if (bus_addr == `MRS_STATUS_ADDR)
                begin
                    raw_word = {28'h000_0000, st_q.status};
                end
            end
            default:
            begin
                raw_word = 32'h0000_0000;
            end
        endcase
        shifted = raw_word >> {bus_addr[1:0], 3'b000};
        if (bus_size == `MRS_SIZE_BYTE)
        begin
            shifted = {24'h00_0000, shifted[7:0]};
        end
        else if (bus_size == `MRS_SIZE_HALF)
        begin
            shifted = {16'h0000, shifted[15:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers, answer and reset capture
    always_comb
    begin
        st_d = st_q;
        st_d.ack = bus_valid;
        st_d.abort = 1'b0;
        st_d.sw_req = 1'b0;
        st_d.rdata = 32'h0000_0000;
        if (bus_valid)
        begin
            if (tgt == MRS_TGT_NONE || !aligned)
            begin
                st_d.abort = 1'b1;
            end
            else if (!bus_write)
            begin
                st_d.rdata = shifted;
            end
            else if (tgt == MRS_TGT_REG)
            begin
                if (bus_addr == `MRS_REMAP_ADDR)
                begin
                    // only bit 0 is kept, upper bits ignored
                    st_d.remap = bus_wdata[`MRS_REMAP_BIT];
                end
                else if (bus_addr == `MRS_STATUS_ADDR)
                begin
                    // status write starts a software reset
                    st_d.status[`MRS_RST_SW_BIT] = 1'b1;
                    st_d.sw_req = 1'b1;
                end
                else
                begin
                    st_d.status = st_q.status & ~bus_wdata[3:0];
                    // software bit left set resets again
                    if (st_q.status[`MRS_RST_SW_BIT] &&
                        !bus_wdata[`MRS_RST_SW_BIT])
                    begin
                        st_d.sw_req = 1'b1;
                    end
                end
            end
        end
        // kernel runs first, then core jumps to zero
        if (kernel_done)
        begin
            st_d.kernel = 1'b0;
        end
        if (!reset_n)
        begin
            // any reset brings flash back to zero
            st_d.remap = `MRS_REMAP_RESET;
            st_d.kernel = `MRS_KERNEL_RESET;
            st_d.sw_req = 1'b0;
            st_d.ack = 1'b0;
            st_d.abort = 1'b0;
            st_d.rdata = 32'h0000_0000;
            // status keeps the source of the reset
            // bit order power, watchdog, software, external
            if (rst_cause_por)
            begin
                // Power-on wipes older history too
                st_d.status = 4'h0;
                st_d.status[`MRS_RST_POR_BIT] = 1'b1;
            end
            else
            begin
                st_d.status[`MRS_RST_WDOG_BIT] =
                    st_q.status[`MRS_RST_WDOG_BIT] | rst_cause_wdog;
                st_d.status[`MRS_RST_EXT_BIT] =
                    st_q.status[`MRS_RST_EXT_BIT] | rst_cause_ext;
            end
        end
    end

    // Single register stage for the whole state
    always_ff @(posedge mclk)
    begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus_ack = st_q.ack;
    assign bus_abort = st_q.abort;
    assign bus_rdata = st_q.rdata;
    assign sw_reset_req = st_q.sw_req;
    assign kernel_active = st_q.kernel;

endmodule : mrs_decoder

// *** inc/mrs_defs.svh ***
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

// Address map
`define MRS_WIN_BASE 32'h0000_0000
`define MRS_WIN_BITS 16
`define MRS_SRAM_BASE 32'h0004_0000
`define MRS_SRAM_BITS 12
`define MRS_SRAM_WORDS 1024
`define MRS_FLASH_BASE 32'h0008_0000
`define MRS_FLASH_BITS 16
`define MRS_KERNEL_BASE 16'hF800
`define MRS_MMR_BASE 32'hFFFF_0000
`define MRS_MMR_BITS 12

// Register byte addresses
`define MRS_REMAP_ADDR 32'hFFFF_0220
`define MRS_STATUS_ADDR 32'hFFFF_0230
`define MRS_CLEAR_ADDR 32'hFFFF_0234

// Field positions
`define MRS_REMAP_BIT 0
`define MRS_RST_POR_BIT 0
`define MRS_RST_WDOG_BIT 1
`define MRS_RST_SW_BIT 2
`define MRS_RST_EXT_BIT 3

// Reset values
`define MRS_REMAP_RESET 1'b0
`define MRS_KERNEL_RESET 1'b1

// Transfer sizes
`define MRS_SIZE_BYTE 2'h0
`define MRS_SIZE_HALF 2'h1
`define MRS_SIZE_WORD 2'h2

// Interrupt latency bounds, core cycles
`define MRS_IRQ_MIN_CYCLES 5
`define MRS_FIQ_MAX_CYCLES 50

`endif

// *** inc/mrs_pkg.sv ***
package mrs_pkg;

    // Target of one bus access
    typedef enum logic [2:0] {
        MRS_TGT_NONE,
        MRS_TGT_SRAM,
        MRS_TGT_FLASH,
        MRS_TGT_REG,
        MRS_TGT_MMR
    } mrs_target_t;

    // Synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } mrs_sync_t;

    // Decoder state
    typedef struct packed {
        logic remap;
        logic [3:0] status;
        logic kernel;
        logic sw_req;
        logic ack;
        logic abort;
        logic [31:0] rdata;
    } mrs_state_t;

endpackage : mrs_pkg

// *** hdl/mrs_sync3.sv ***
`timescale 1ns/100ps
`include "mrs_defs.svh"

module mrs_sync3
    import mrs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Asynchronous input and clean level
    input wire logic async_in,
    output logic level
);

    mrs_sync_t st_q;
    mrs_sync_t st_d;

    ////////////////////////////////////////////////////////////////////
    // Three stages; level moves only when stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.level = st_q.s3;
        end
        if (!reset_n)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        st_q <= st_d;
    end

    assign level = st_q.level;

endmodule : mrs_sync3

// *** verif/mrs_mem_model.sv ***
`timescale 1ns/100ps
module mrs_mem_model (
    // Requests from the decoder
    input wire logic flash_req,
    input wire logic [15:0] flash_addr,
    input wire logic mmr_req,
    input wire logic [11:0] mmr_addr,
    // Read data back
    output logic [31:0] flash_rdata,
    output logic [31:0] mmr_rdata
);
    ////////////////////////////////////////////////////////////
    // words keyed by address
    // Idle lines show the inverse so stale data never passes
    assign flash_rdata = {32{!flash_req}} ^
        {16'hf1a5, flash_addr[15:2], 2'h0};
    assign mmr_rdata = {32{!mmr_req}} ^
        {16'hc3c3, 4'h0, mmr_addr[11:2], 2'h0};
endmodule : mrs_mem_model

// *** verif/mrs_props.sv ***
`timescale 1ns/100ps
`include "mrs_defs.svh"
module mrs_props
    import mrs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Core bus
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_addr,
    input wire logic bus_ack,
    input wire logic bus_abort,
    input wire logic [31:0] bus_rdata,
    // Control
    input wire logic sw_reset_req,
    input wire logic kernel_active,
    input wire logic exc_wide_isa,
    // Interrupts
    input wire logic fast_interrupt_request_pin,
    input wire logic fast_interrupt_request_sync,
    input wire logic irq_pin,
    input wire logic irq_sync
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////
    // Pin seen high for five edges running
    sequence s_pin_held(p);
        $rose(p) ##1 p [*4];
    endsequence
    property p_sync(p, s);
        s_pin_held(p) |-> s;
    endproperty

    // Bus answers
    a_ack_follows: assert property (bus_valid |=> bus_ack)
        else $error("ack missing after request");
    a_ack_cause: assert property (bus_ack |-> $past(bus_valid))
        else $error("ack without request");
    a_abort_clean: assert property (
        bus_abort |-> bus_ack && bus_rdata == 32'h0000_0000)
        else $error("abort without ack or with data");
    a_hole_abort: assert property (bus_valid &&
        bus_addr[31:16] inside {[16'h0001:16'h0003]} |=> bus_abort)
        else $error("hole access not aborted");
    a_sram_end: assert property (bus_valid &&
        bus_addr[31:12] == 20'h0004_1 |=> bus_abort)
        else $error("access past sram not aborted");
    a_kernel_hidden: assert property (bus_valid &&
        !kernel_active && bus_addr[31:11] == 21'h0_011f |=> bus_abort)
        else $error("kernel area readable by user");
    // Reset control
    a_status_write: assert property (bus_valid && bus_write &&
        bus_addr == `MRS_STATUS_ADDR && bus_size == `MRS_SIZE_WORD
        |=> sw_reset_req)
        else $error("status write gave no reset request");
    a_swreq_cause: assert property (sw_reset_req |->
        $past(bus_valid) && $past(bus_write))
        else $error("reset request without a write");
    a_boot_kernel: assert property ($rose(reset_n) |-> kernel_active)
        else $error("kernel phase missing after reset");
    a_isa_wide: assert property (exc_wide_isa)
        else $error("exception entry not in wide set");
    // Interrupt synchronisers
    a_fast_sync: assert property (
        p_sync(fast_interrupt_request_pin, fast_interrupt_request_sync))
        else $error("fast request not passed in time");
    a_irq_sync: assert property (p_sync(irq_pin, irq_sync))
        else $error("normal request not passed in time");
    a_sync_min: assert property ($rose(fast_interrupt_request_sync)
        |-> $past(fast_interrupt_request_pin, 2))
        else $error("fast request passed too early");
endmodule : mrs_props

bind mrs_decoder mrs_props u_props (.mclk, .reset_n, .bus_valid,
    .bus_write, .bus_size, .bus_addr, .bus_ack, .bus_abort, .bus_rdata,
    .sw_reset_req, .kernel_active, .exc_wide_isa,
    .fast_interrupt_request_pin, .fast_interrupt_request_sync,
    .irq_pin, .irq_sync);

// *** verif/mrs_decoder_tb.sv ***
`timescale 1ns/100ps
`include "mrs_defs.svh"
module mrs_decoder_tb;
    localparam logic [1:0] B = `MRS_SIZE_BYTE;
    localparam logic [1:0] H = `MRS_SIZE_HALF;
    localparam logic [1:0] W = `MRS_SIZE_WORD;
    localparam logic [31:0] RMP = `MRS_REMAP_ADDR;
    localparam logic [31:0] STA = `MRS_STATUS_ADDR;
    localparam logic [31:0] CLR = `MRS_CLEAR_ADDR;
    // Stimulus and observed ports
    logic mclk = 0, reset_n = 0, kernel_done = 0, bus_valid = 0;
    logic rst_cause_por = 1, rst_cause_wdog = 0, rst_cause_ext = 0;
    logic bus_write = 0, fast_interrupt_request_pin = 0, irq_pin = 0;
    logic [1:0] bus_size = 0, flash_size, l;
    logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata, a, w, e;
    logic sw_reset_req, kernel_active, bus_ack, bus_abort, flash_req;
    logic flash_write, mmr_req, mmr_write, irq_sync, exc_wide_isa;
    logic fast_interrupt_request_sync, sw_s;
    logic [15:0] flash_addr;
    logic [11:0] mmr_addr;
    logic [31:0] flash_wdata, flash_rdata, mmr_wdata, mmr_rdata;
    logic [7:0] b;
    logic [3:0] st;
    int n_fail = 0, n_compared = 0, seed = 32'h61e1;

    // 125 MHz core clock
    always #4 mclk = ~mclk;

    mrs_decoder u_dut (.mclk, .reset_n, .rst_cause_por, .rst_cause_wdog,
        .rst_cause_ext, .sw_reset_req, .kernel_done, .kernel_active,
        .bus_valid, .bus_write, .bus_size, .bus_addr, .bus_wdata, .bus_ack,
        .bus_abort, .bus_rdata, .flash_req, .flash_write, .flash_size,
        .flash_addr, .flash_wdata, .flash_rdata, .mmr_req, .mmr_write,
        .mmr_addr, .mmr_wdata, .mmr_rdata, .fast_interrupt_request_pin,
        .irq_pin, .fast_interrupt_request_sync, .irq_sync, .exc_wide_isa);
    mrs_mem_model u_mem (.flash_req, .flash_addr, .mmr_req, .mmr_addr,
        .flash_rdata, .mmr_rdata);

    ////////////////////////////////////////////////////////////
    // Expected words and status after a reset
    function automatic logic [31:0] fw(input logic [15:0] x);
        return {16'hf1a5, x[15:2], 2'h0};
    endfunction : fw
    function automatic logic [3:0] after(input logic [3:0] s,
        input logic p, g, x);
        return p ? 4'h1 : s | {x, 1'b0, g, 1'b0};
    endfunction : after

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // One access; entered just after an edge, answer one cycle later
    task automatic op(input logic wr, input logic [1:0] s,
        input logic [31:0] ad, d, ex, input logic ab);
        bus_valid = 1;
        bus_write = wr;
        bus_size = s;
        bus_addr = ad;
        bus_wdata = d;
        cyc(1);
        bus_valid = 0;
        sw_s = sw_reset_req;
        chk("ack", bus_ack, 1);
        chk("abort", bus_abort, ab);
        if (!wr)
            chk("rdata", bus_rdata, ex);
        cyc(1);
    endtask : op
    // Forwarded write, looked at while the request stands
    task automatic fwd(input logic [1:0] s, input logic [31:0] ad, d,
        input logic [3:0] rq, input logic [31:0] ln);
        bus_valid = 1;
        bus_write = 1;
        bus_size = s;
        bus_addr = ad;
        bus_wdata = d;
        #1;
        chk("req", {flash_req, mmr_req, flash_write, mmr_write}, rq);
        chk("fsize", flash_size, s);
        chk("faddr", flash_addr, ad[15:0]);
        chk("maddr", mmr_addr, ad[11:0]);
        chk("fdata", flash_wdata, ln);
        chk("mdata", mmr_wdata, ln);
        cyc(1);
        bus_valid = 0;
        chk("ack", bus_ack, 1);
        chk("abort", bus_abort, 0);
        cyc(1);
    endtask : fwd
    // Reset generator: causes held with reset low
    task automatic rst(input logic p, g, x, input int n);
        rst_cause_por = p;
        rst_cause_wdog = g;
        rst_cause_ext = x;
        reset_n = 0;
        cyc(n);
        reset_n = 1;
        rst_cause_por = 0;
        rst_cause_wdog = 0;
        rst_cause_ext = 0;
        st = after(st, p, g, x);
        chk("kernel", kernel_active, 1);
        op(0, W, RMP, 0, 0, 0);
        op(0, W, STA, 0, {28'h0, st}, 0);
        op(0, W, 32'h0008_f800, 0, fw(16'hf800), 0);
    endtask : rst

    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        st = 4'h0;
        rst(1, 0, 0, 10);
        op(0, W, CLR, 0, 0, 0);
        chk("wide", exc_wide_isa, 1);
        kernel_done = 1;
        cyc(1);
        kernel_done = 0;
        chk("kernel", kernel_active, 0);
        $display("test reset state done");
        // Random sram traffic, lanes little-endian
        repeat (24)
        begin
            a = 32'h0004_0000 | (32'($random(seed)) & 32'h0000_0ffc);
            w = $random(seed);
            b = 8'($random(seed));
            l = 2'($random(seed));
            op(1, W, a, w, 0, 0);
            op(1, B, a + 32'(l), {24'h0, b}, 0, 0);
            e = w;
            e[8 * l +: 8] = b;
            op(0, W, a, 0, e, 0);
            op(0, H, a + {30'h0, l[1], 1'b0}, 0,
                (e >> (16 * l[1])) & 32'h0000_ffff, 0);
            op(0, B, a + 3, 0, {24'h0, e[31:24]}, 0);
        end
        $display("test sram done");
        // Holes, bad sizes and boundaries
        op(0, W, 32'h0004_1000, 0, 0, 1);
        op(1, W, 32'h0002_0000, 1, 0, 1);
        op(0, 2'h3, 32'h0004_0000, 0, 0, 1);
        op(0, H, 32'h0004_0001, 0, 0, 1);
        op(0, W, 32'hfffe_fffc, 0, 0, 1);
        op(0, W, 32'hffff_0ffc, 0, {16'hc3c3, 16'h0ffc}, 0);
        op(0, W, 32'h0000_0100, 0, fw(16'h0100), 0);
        op(0, W, 32'h0008_f7fc, 0, fw(16'hf7fc), 0);
        op(0, W, 32'h0008_f800, 0, 0, 1);
        op(0, W, 32'h0000_fffc, 0, 0, 1);
        fwd(H, 32'h0008_0002, 32'h0000_beef, 4'b1011, 32'hbeef_beef);
        fwd(B, 32'hffff_0011, 32'h0000_005a, 4'b0111, 32'h5a5a_5a5a);
        $display("test map done");
        // Remap the window to sram and back
        op(1, W, 32'h0004_0000, 32'h1234_5678, 0, 0);
        op(1, W, RMP, 1, 0, 0);
        chk("swreq", sw_s, 0);
        op(0, W, RMP, 0, 1, 0);
        op(0, W, 32'h0000_0000, 0, 32'h1234_5678, 0);
        op(1, W, 32'h0000_0004, 32'h0bad_cafe, 0, 0);
        op(0, W, 32'h0004_0004, 0, 32'h0bad_cafe, 0);
        op(0, W, 32'h0000_1000, 0, 0, 1);
        op(1, W, RMP, 0, 0, 0);
        op(0, W, 32'h0000_0000, 0, fw(16'h0000), 0);
        $display("test remap done");
        // Software reset, repeated reset and clear
        op(1, W, RMP, 1, 0, 0);
        op(1, W, STA, 0, 0, 0);
        chk("swreq", sw_s, 1);
        st[2] = 1'b1;
        rst(0, 0, 0, 4);
        op(1, W, CLR, 1, 0, 0);
        chk("swreq", sw_s, 1);
        st[0] = 1'b0;
        rst(0, 0, 0, 4);
        op(1, W, CLR, 4, 0, 0);
        chk("swreq", sw_s, 0);
        st = 4'h0;
        op(0, W, STA, 0, 0, 0);
        rst(0, 1, 0, 4);
        rst(0, 0, 1, 4);
        rst(1, 0, 0, 4);
        $display("test reset sources done");
        // Interrupt synchronisers
        fast_interrupt_request_pin = 1;
        irq_pin = 1;
        cyc(2);
        chk("fsync", fast_interrupt_request_sync, 0);
        cyc(4);
        chk("fsync", fast_interrupt_request_sync, 1);
        chk("isync", irq_sync, 1);
        fast_interrupt_request_pin = 0;
        irq_pin = 0;
        cyc(6);
        chk("fsync", fast_interrupt_request_sync, 0);
        chk("isync", irq_sync, 0);
        $display("test interrupts done");
        results();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        results();
    end
endmodule : mrs_decoder_tb
